/* design/gpio_port_pkg.sv */
package gpio_port_pkg;
  // port geometry
  localparam int PORT_WIDTH = 8; // pins per full port
  // drive mode codes, {drive_mode_hi, drive_mode_lo}
  localparam logic [1:0] DM_PULLUP = 2'h0; // resistive high, strong low
  localparam logic [1:0] DM_STRONG = 2'h1; // strong high and low
  localparam logic [1:0] DM_HIZ_ANALOG = 2'h2; // input buffer off
  localparam logic [1:0] DM_OPEN_DRAIN = 2'h3; // strong low, input on
  // reset values
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_DM_LO = 8'h00;
  localparam logic [7:0] RST_DM_HI = 8'hFF; // every pin high-z analog
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_LAST_READ = 8'h00;
  // regulated level field position in the io config byte
  localparam int REG_LEVEL_LSB = 4;
  localparam int REG_LEVEL_MSB = 5;

  // per-pin drive controls toward the pad
  typedef struct packed {
    logic [7:0] out_val; // value placed on the pad
    logic [7:0] out_en; // pad driven
    logic [7:0] pull_up; // resistive pull-up active
    logic [7:0] reg_high; // strong high taken from the regulator
    logic [7:0] in_en; // input buffer on
  } pad_ctrl_type;
endpackage

/* design/gpio_port.sv */
// Contract
// - port of eight identical pin slices
// - written data bit drives pin per mode
// - data read returns sampled pin level
// - input buffer off only in analog mode
// - regulator bit picks regulated strong high level
// - pull-up always pulls to chip supply
// - level field at config bits four, five
// - per-pin enable, one chip-wide mode bit
// - per-pin active-low irq, wire-ORed together
// - pin irq depends on enable and condition
// - shared line asserts by edge, releases level
// - enabling with condition met asserts immediately
// - irq holds until a release condition
// - overlapping sources give no new edge
// - mode zero: irq while pin low
// - mode one: irq when pin differs last read
// - enable zero keeps irq deasserted
// - change-mode read reloads last-read latch
// - two-bit drive mode encoding
// - reset puts every pin in analog mode
// - analog pin reads zero, so irq in low mode if enabled
`timescale 1ns/1ps
`default_nettype none
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = PORT_WIDTH
)(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic data_wr, // one-cycle write strobe of port data
  input wire logic [WIDTH-1:0] data_wdata,
  input wire logic data_rd, // one-cycle read strobe of port data
  input wire logic dm_lo_wr,
  input wire logic dm_hi_wr,
  input wire logic [WIDTH-1:0] dm_wdata,
  input wire logic irq_en_wr,
  input wire logic [WIDTH-1:0] irq_en_wdata,
  input wire logic irq_mode_select, // 0 low level, 1 change
  input wire logic regulator_enable,
  input wire logic [7:0] io_config_reg, // level field read from here
  input wire logic [WIDTH-1:0] pin_in, // asynchronous pad levels
  output logic [WIDTH-1:0] port_rdata, // registered read data
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pin_pullup,
  output logic [WIDTH-1:0] pin_reg_high,
  output logic [1:0] reg_level_sel,
  output logic [WIDTH-1:0] pin_irq_n, // per-pin active-low requests
  output logic gpio_irq // shared request, active high
);

  // stored controls
  logic [WIDTH-1:0] port_data_reg_ff; // output bits
  logic [WIDTH-1:0] drive_mode_lo_ff;
  logic [WIDTH-1:0] drive_mode_upper_reg_ff;
  logic [WIDTH-1:0] pin_irq_enable_reg_ff;
  logic [WIDTH-1:0] last_read_ff; // change-mode reference
  // three-stage input synchroniser
  logic [WIDTH-1:0] sync1_ff;
  logic [WIDTH-1:0] sync2_ff;
  logic [WIDTH-1:0] sync3_ff;
  logic [WIDTH-1:0] pin_level_ff; // debounced: changes when 2 and 3 agree
  // registered outputs
  logic [WIDTH-1:0] rdata_ff;
  logic [WIDTH-1:0] irq_n_ff;
  logic irq_ff;
  pad_ctrl_type pad_ff;
  logic [1:0] lvl_ff;

  // per-pin match of the two mode bits against one mode code
  function automatic logic [WIDTH-1:0] mode_is(
    input logic [WIDTH-1:0] hi,
    input logic [WIDTH-1:0] lo,
    input logic [1:0] code
  );
    return (code[1] ? hi : ~hi) & (code[0] ? lo : ~lo);
  endfunction

  // decode of drive mode per pin; one code each, so modes never overlap
  wire logic [WIDTH-1:0] is_analog = mode_is(drive_mode_upper_reg_ff,
    drive_mode_lo_ff, DM_HIZ_ANALOG);
  wire logic [WIDTH-1:0] is_strong = mode_is(drive_mode_upper_reg_ff,
    drive_mode_lo_ff, DM_STRONG);
  wire logic [WIDTH-1:0] is_pullup = mode_is(drive_mode_upper_reg_ff,
    drive_mode_lo_ff, DM_PULLUP);
  wire logic [WIDTH-1:0] is_odrain = mode_is(drive_mode_upper_reg_ff,
    drive_mode_lo_ff, DM_OPEN_DRAIN);
  // analog pins have their input buffer off and read as zero
  wire logic [WIDTH-1:0] in_en = ~is_analog;
  wire logic [WIDTH-1:0] sampled = pin_level_ff & in_en;
  // drive: low driven strongly unless analog; high only when strong
  wire logic [WIDTH-1:0] nxt_oe = (is_strong
    | ((is_pullup | is_odrain) & ~port_data_reg_ff));
  wire logic [WIDTH-1:0] nxt_pull = is_pullup
    & port_data_reg_ff;
  wire logic [WIDTH-1:0] nxt_regh = is_strong
    & {WIDTH{regulator_enable}};
  // interrupt condition: level low, or differs from last read
  wire logic [WIDTH-1:0] cond = irq_mode_select
    ? (sampled ^ last_read_ff) : ~sampled;
  wire logic [WIDTH-1:0] nxt_irq_n = ~(pin_irq_enable_reg_ff
    & cond);
  // a read of the port also refreshes the change reference
  wire logic [WIDTH-1:0] nxt_last_read = data_rd ? sampled
    : last_read_ff;

  // input synchroniser; stage one feeds only stage two
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      pin_level_ff <= '0;
    end
    else
    begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      // a bit is taken once stages two and three agree
      pin_level_ff <= (sync2_ff & sync3_ff)
        | (pin_level_ff & (sync2_ff | sync3_ff));
    end
  end

  // software writable controls, one bit per slice
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      port_data_reg_ff <= RST_DATA;
      drive_mode_lo_ff <= RST_DM_LO;
      drive_mode_upper_reg_ff <= RST_DM_HI;
      pin_irq_enable_reg_ff <= RST_IRQ_EN;
    end
    else
    begin
      if (data_wr)
        port_data_reg_ff <= data_wdata;
      if (dm_lo_wr)
        drive_mode_lo_ff <= dm_wdata;
      if (dm_hi_wr)
        drive_mode_upper_reg_ff <= dm_wdata;
      if (irq_en_wr)
        pin_irq_enable_reg_ff <= irq_en_wdata;
    end
  end

  // read path and last-read latch; reads return pins, not stored bits
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_ff <= '0;
      last_read_ff <= RST_LAST_READ;
    end
    else
    begin
      // read data is held between reads so software sees a stable word
      if (data_rd)
        rdata_ff <= sampled;
      last_read_ff <= nxt_last_read;
    end
  end

  // pad controls and interrupt outputs, one slice per pin
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pad_ff <= '0;
      lvl_ff <= '0;
      irq_n_ff <= '1;
      irq_ff <= 1'b0;
    end
    else
    begin
      pad_ff.out_val <= port_data_reg_ff & ~is_analog;
      pad_ff.out_en <= nxt_oe;
      pad_ff.pull_up <= nxt_pull;
      pad_ff.reg_high <= nxt_regh;
      pad_ff.in_en <= in_en;
      lvl_ff <= io_config_reg[REG_LEVEL_MSB:REG_LEVEL_LSB];
      // per-pin term follows condition, so it holds until released
      irq_n_ff <= nxt_irq_n;
      // shared line is the OR; a second source hides a release
      irq_ff <= |(~nxt_irq_n);
    end
  end

  assign port_rdata = rdata_ff;
  assign pin_out = pad_ff.out_val;
  assign pin_oe = pad_ff.out_en;
  assign pin_pullup = pad_ff.pull_up;
  assign pin_reg_high = pad_ff.reg_high;
  assign reg_level_sel = lvl_ff;
  assign pin_irq_n = irq_n_ff;
  assign gpio_irq = irq_ff;

  // all checks sample on the system clock and sleep while in reset
  // shared line equals OR of the per-pin requests, same cycle
  chk_shared_irq_or: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    gpio_irq == |(~pin_irq_n))
    else $error("shared irq mismatch");
  // disabled pin never requests
  chk_disabled_quiet: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !pin_irq_enable_reg_ff[0] |=> pin_irq_n[0])
    else $error("disabled pin requests");
  // low mode, enabled, low sampled pin requests next cycle
  chk_low_mode: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (!irq_mode_select && pin_irq_enable_reg_ff[0] && !sampled[0])
    |=> !pin_irq_n[0])
    else $error("low mode irq missing");
  // change mode requests when pin differs from last read
  chk_change_mode: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (irq_mode_select && pin_irq_enable_reg_ff[0]
    && (sampled[0] != last_read_ff[0]))
    |=> !pin_irq_n[0])
    else $error("change irq missing");
  // setting the enable with the pin already low requests at once
  chk_enable_now: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    ($rose(pin_irq_enable_reg_ff[0]) && !irq_mode_select && !sampled[0])
    |=> !pin_irq_n[0])
    else $error("enable did not request");
  // a read loads the latch with the value read
  chk_read_latch: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    data_rd |=> (last_read_ff == rdata_ff))
    else $error("latch not loaded");
  // a change-mode read, then a pin that holds still one more cycle
  sequence change_read;
    irq_mode_select && data_rd;
  endsequence
  sequence pin_steady;
    $stable(sampled[0]) && irq_mode_select;
  endsequence
  // such a read moves the reference, so the request drops
  chk_read_release: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    change_read ##1 pin_steady |=> pin_irq_n[0])
    else $error("read did not release");
  // digital pins read their synchronised level, not the stored bit
  chk_read_pins: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (data_rd && !is_analog[0])
    |=> port_rdata[0] == $past(pin_level_ff[0]))
    else $error("read data not pin level");
  // analog pins read zero
  chk_analog_zero: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (data_rd && is_analog[0]) |=> !port_rdata[0])
    else $error("analog pin read one");
  // analog pins have their input buffer switched off
  chk_input_off: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    is_analog[0] |=> !pad_ff.in_en[0])
    else $error("analog input buffer on");
  // strong mode drives the stored bit one cycle on if unchanged
  sequence strong_steady;
    is_strong[0] && $stable(port_data_reg_ff[0]);
  endsequence
  chk_strong_drive: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    strong_steady
    |=> (pin_oe[0] && pin_out[0] == $past(port_data_reg_ff[0])))
    else $error("strong drive wrong");
  // pull-up pin with data zero is pulled low strongly
  chk_pullup_low: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (is_pullup[0] && !port_data_reg_ff[0]) |=> (pin_oe[0] && !pin_out[0]))
    else $error("pull-up low not driven");
  // open-drain pin with data one leaves the pad undriven
  chk_open_high: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (is_odrain[0] && port_data_reg_ff[0]) |=> !pin_oe[0])
    else $error("open drain drives high");
  // pull-up never marked as regulated
  chk_pullup_vdd: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    is_pullup[0] |=> !pin_reg_high[0])
    else $error("pull-up regulated");
  // regulator follows enable for strong pins
  chk_reg_high: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (is_strong[0] && regulator_enable) |=> pin_reg_high[0])
    else $error("regulated high missing");
  // level field copied a cycle after it changes
  chk_level_copy: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $changed(io_config_reg)
    |=> reg_level_sel == $past(io_config_reg[REG_LEVEL_MSB:REG_LEVEL_LSB]))
    else $error("level field not copied");

endmodule
`default_nettype wire

/* tb/pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
// board side of the eight pads
module pad_model (
  input wire logic clk_sys,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] ext_en, // board driver active
  input wire logic [7:0] ext_val, // board driver level
  output logic [7:0] pin_lvl
);
  // an undriven pad toggles each cycle, so the synchroniser keeps its last settled level
  logic [7:0] float_ff = 8'h55;
  always_ff @(posedge clk_sys)
  begin
    float_ff <= ~float_ff;
  end
  // port drive wins, then the board, then the resistor
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | float_ff));
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gpio_port_pkg::*;
  logic clk_sys, rstn, data_wr, data_rd, dm_lo_wr, dm_hi_wr, irq_en_wr;
  logic irq_mode_select, regulator_enable, gpio_irq;
  logic [7:0] data_wdata, dm_wdata, irq_en_wdata, io_config_reg, pin_in;
  logic [7:0] port_rdata, pin_out, pin_oe, pin_pullup, pin_reg_high;
  logic [7:0] pin_irq_n, ext_en, ext_val, d, last;
  logic [1:0] reg_level_sel;
  int fails, tests_run, seed;
  gpio_port dut (.clk_sys(clk_sys), .rstn(rstn), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rd(data_rd), .dm_lo_wr(dm_lo_wr),
    .dm_hi_wr(dm_hi_wr), .dm_wdata(dm_wdata), .irq_en_wr(irq_en_wr),
    .irq_en_wdata(irq_en_wdata), .irq_mode_select(irq_mode_select),
    .regulator_enable(regulator_enable), .io_config_reg(io_config_reg),
    .pin_in(pin_in), .port_rdata(port_rdata), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_reg_high(pin_reg_high),
    .reg_level_sel(reg_level_sel), .pin_irq_n(pin_irq_n),
    .gpio_irq(gpio_irq));
  pad_model pads (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val),
    .pin_lvl(pin_in));
  // 125 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one-cycle strobe: 0 data, 1 mode lo, 2 mode hi, 3 irq enable, 4 read
  task automatic pulse(input int k, input logic [7:0] v);
    @(negedge clk_sys);
    {data_rd, irq_en_wr, dm_hi_wr, dm_lo_wr, data_wr} = 5'h01 << k;
    data_wdata = v;
    dm_wdata = v;
    irq_en_wdata = v;
    @(negedge clk_sys);
    {data_rd, irq_en_wr, dm_hi_wr, dm_lo_wr, data_wr} = 5'h00;
  endtask
  // synchroniser plus request register need about five edges
  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // active-high pin requests expected from enable, level and mode
  function automatic logic [7:0] irq_exp(input logic [7:0] ie, lvl, lr,
    input logic mode);
    return mode ? ie & (lvl ^ lr) : ie & ~lvl;
  endfunction
  // eight random bits from the fixed seed, cut on purpose
  function automatic logic [7:0] rnd8();
    return 8'($random(seed));
  endfunction
  // a hang counts against the run
  initial
  begin
    #100000;
    fails++;
    end_of_test();
  end
  initial
  begin
    seed = 4;
    {rstn, data_wr, data_rd, dm_lo_wr, dm_hi_wr, irq_en_wr} = 6'h00;
    {data_wdata, dm_wdata, irq_en_wdata, io_config_reg} = 32'h0;
    {irq_mode_select, regulator_enable} = 2'h0;
    ext_en = 8'hFF;
    ext_val = 8'hFF;
    settle(5);
    rstn = 1'b1;
    check(pin_oe | pin_pullup, 8'h00);
    check(pin_irq_n, 8'hFF);
    // let the driven pads pass the synchroniser before reading them
    settle(8);
    check(pin_oe | pin_pullup | pin_out, 8'h00);
    pulse(4, 8'h00);
    check(port_rdata, 8'h00);
    // strong mode, regulator on
    pulse(1, 8'hFF);
    pulse(2, 8'h00);
    ext_en = 8'h00;
    d = rnd8();
    io_config_reg = rnd8();
    regulator_enable = 1'b1;
    pulse(0, d);
    settle(8);
    check(pin_out, d);
    check(pin_oe, 8'hFF);
    check(pin_reg_high, 8'hFF);
    check({6'h00, reg_level_sel}, {6'h00, io_config_reg[5:4]});
    pulse(4, 8'h00);
    check(port_rdata, d);
    // regulator off: strong high goes to the chip supply
    regulator_enable = 1'b0;
    settle(2);
    check(pin_reg_high, 8'h00);
    // pull-up input with data one, board pulls some pins
    pulse(1, 8'h00);
    pulse(0, 8'hFF);
    ext_en = rnd8();
    ext_val = rnd8();
    settle(8);
    check(pin_pullup, 8'hFF);
    check(pin_reg_high, 8'h00);
    pulse(4, 8'h00);
    check(port_rdata, (ext_en & ext_val) | ~ext_en);
    // data zero in pull-up mode drives the low pins strongly
    pulse(0, 8'hF0);
    settle(2);
    check(pin_oe, 8'h0F);
    check(pin_pullup, 8'hF0);
    // open drain input, low level mode chosen before enables
    pulse(1, 8'hFF);
    pulse(2, 8'hFF);
    pulse(0, 8'hFF);
    ext_en = 8'hFF;
    irq_mode_select = 1'b0;
    repeat (6)
    begin
      d = rnd8();
      ext_val = rnd8();
      pulse(3, d);
      settle(8);
      d = irq_exp(d, ext_val, 8'h00, 1'b0);
      check(~pin_irq_n, d);
      check({7'h00, gpio_irq}, {7'h00, |d});
    end
    check(pin_oe, 8'h00);
    ext_val = 8'hFE;
    pulse(3, 8'h00);
    settle(8);
    check(pin_irq_n, 8'hFF);
    pulse(3, 8'h03);
    settle(2);
    check(pin_irq_n, 8'hFE);
    ext_val = 8'hFC;
    settle(8);
    ext_val = 8'hFD;
    repeat (8)
    begin
      @(negedge clk_sys);
      check({7'h00, gpio_irq}, 8'h01);
    end
    check(pin_irq_n, 8'hFD);
    ext_val = 8'hFF;
    settle(8);
    check({7'h00, gpio_irq}, 8'h00);
    // change mode, every service reads the port
    irq_mode_select = 1'b1;
    pulse(3, 8'hFF);
    pulse(4, 8'h00);
    last = 8'hFF;
    repeat (6)
    begin
      ext_val = rnd8();
      settle(8);
      check(~pin_irq_n, irq_exp(8'hFF, ext_val, last, 1'b1));
      pulse(4, 8'h00);
      check(port_rdata, ext_val);
      last = ext_val;
      settle(1);
      check(pin_irq_n, 8'hFF);
    end
    ext_val = ~last;
    settle(8);
    check({7'h00, gpio_irq}, 8'h01);
    pulse(3, 8'h00);
    settle(2);
    check({7'h00, gpio_irq}, 8'h00);
    // mid-run reset puts every pin back to analog and drops requests
    @(negedge clk_sys);
    rstn = 1'b0;
    settle(2);
    rstn = 1'b1;
    settle(8);
    check(pin_oe | pin_pullup | pin_out, 8'h00);
    check({7'h00, gpio_irq}, 8'h00);
    pulse(4, 8'h00);
    check(port_rdata, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
